// *** rtl/dmace_pkg.sv ***
// Constants and types of the DMA channel mode engine.
// Assumes a 32-bit register port addressed in bytes, one word per register.
package dmace_pkg;

  localparam int NCH = 4;
  localparam int AW  = 24;
  localparam int RAW = 8;
  localparam int DW  = 32;

  // Register byte offsets within one channel, channel stride 0x10
  localparam logic [3:0] OFF_MAR  = 4'h0;
  localparam logic [3:0] OFF_IO_SIDE_ADDRESS_LOW = 4'h4;
  localparam logic [3:0] OFF_CNT  = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hc;
  localparam logic [RAW-1:0] MAP_END = 8'h40;

  // Control word fields
  localparam int B_EN    = 0;
  localparam int B_SIZE  = 1;
  localparam int B_STEP  = 2;
  localparam int B_DEC   = 3;
  localparam int B_IRQ   = 4;
  localparam int B_SMODE = 5;
  localparam int B_SEL   = 8;
  localparam int B_FULL  = 11;
  localparam int B_BLOCK = 12;
  localparam int B_TMS   = 13;
  localparam int B_ME    = 14;
  localparam int B_PEND  = 16;
  localparam int B_BACT  = 17;
  localparam logic [DW-1:0] CTRL_WMASK = 32'h00007f7f;

  // Reset values
  localparam logic [AW-1:0] MAR_RST  = 24'h000000;
  localparam logic [7:0]    IO_SIDE_ADDRESS_LOW_RST = 8'h00;
  localparam logic [15:0]   CNT_RST  = 16'h0000;
  localparam logic [DW-1:0] CTRL_RST = 32'h00000000;
  localparam logic [1:0]    EXT_RST  = 2'h3;

  // Fixed upper bits of the I/O-side address
  localparam logic [15:0] IO_HI = 16'hffff;

  // Short address modes
  localparam logic [1:0] SM_IO   = 2'h0;
  localparam logic [1:0] SM_IDLE = 2'h1;
  localparam logic [1:0] SM_RPT  = 2'h2;

  // Trigger select codes
  localparam logic [2:0] SEL_TMR0     = 3'h0;
  localparam logic [2:0] SEL_TMR1     = 3'h1;
  localparam logic [2:0] SEL_TMR2     = 3'h2;
  localparam logic [2:0] SEL_TMR3     = 3'h3;
  localparam logic [2:0] SEL_SCI_TX   = 3'h4;
  localparam logic [2:0] SEL_SCI_RX   = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL = 3'h6;
  localparam logic [2:0] SEL_EXT_LOW  = 3'h7;
  localparam logic [2:0] SEL_BURST    = 3'h0;
  localparam logic [2:0] SEL_CSTEAL   = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_HOLD = 3'b100
  } dmace_state_t;

endpackage

// *** rtl/dmace_engine.sv ***
// Four-channel DMA engine: short address modes per channel, full
// address normal and block modes per channel pair, fixed priority.
// Assumes a bus agent that performs one unit move per xfer_valid_o
// and answers with a one-cycle xfer_done_i.
//
// Contract
// - Block mode selects 0-3 pick timer events
// - Block select 110 is request pin fall
// - Shared trigger served in fixed priority order
// - Four short channels; pin only on B
// - Full mode pairs A and B; burst/steal
// - I/O mode moves one unit per request
// - Serial receive trigger copies I/O to memory
// - Idle mode keeps both addresses fixed
// - Repeat mode reloads address, count; no interrupt
// - Auto request starts on enables alone
// - Cycle steal frees bus after each unit
// - Burst keeps bus unless higher master asks
// - External normal: one unit, 24-bit addresses
// - Block per request, block address restored
// - I/O mode memory address steps each unit
// - I/O address upper bits forced ones
// - Counter decrements; zero clears transfer enable
// - Completion pulse when interrupt enable set
// - Start count zero means 65536 units
// - I/O triggers: timers, serial, request pin
// - Size bit: byte step 1, word 2
// - Run needs master and transfer enable
// - NMI clears master enable; resume on set
`timescale 1ns/1ps
`default_nettype none

module dmace_engine (
  input  wire logic                     clk_sys_i,
  input  wire logic                     nrst_i,
  input  wire logic [dmace_pkg::RAW-1:0] reg_addr_i,
  input  wire logic [dmace_pkg::DW-1:0]  reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [dmace_pkg::DW-1:0]  reg_rdata_o,
  input  wire logic [3:0]                tmr_cmp_a_i,
  input  wire logic                     sci0_tx_empty_i,
  input  wire logic                     sci0_rx_full_i,
  input  wire logic [1:0]                ext_xfer_req_n_i,
  input  wire logic                     nmi_i,
  input  wire logic                     hp_bus_req_i,
  input  wire logic                     xfer_done_i,
  output logic                          xfer_valid_o,
  output logic      [dmace_pkg::AW-1:0]  xfer_src_addr_o,
  output logic      [dmace_pkg::AW-1:0]  xfer_dst_addr_o,
  output logic                          xfer_word_o,
  output logic                          bus_own_o,
  output logic      [dmace_pkg::NCH-1:0] xfer_end_o
);
  import dmace_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // State
  logic [AW-1:0]  mar_reg  [NCH];
  logic [7:0]     io_side_address_low_reg [NCH];
  logic [15:0]    cnt_reg  [NCH];
  logic [DW-1:0]  ctrl_reg [NCH];
  logic [NCH-1:0] pend_reg;
  logic [NCH-1:0] bact_reg;
  logic [1:0]     ext_meta_reg;
  logic [1:0]     ext_sync_reg;
  logic [1:0]     ext_prev_reg;
  dmace_state_t   state_reg;
  logic [1:0]     cur_reg;

  logic [2:0]     sel [NCH];
  logic [NCH-1:0] is_full;
  logic [NCH-1:0] is_slave;
  logic [NCH-1:0] is_blk;
  logic [NCH-1:0] run;
  logic [NCH-1:0] hit;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] auto_rq;
  logic [NCH-1:0] rdy;
  logic [1:0]     ext_fall;
  logic [1:0]     ext_low;
  logic [1:0]     grant;
  logic           any;
  logic           keep;
  logic           iss;
  logic [1:0]     iss_ch;
  logic [1:0]     iss_b;
  logic [AW-1:0]  iss_src;
  logic [AW-1:0]  iss_dst;
  logic           done;
  logic [AW-1:0]  n_mar [NCH];
  logic [15:0]    n_cnt [NCH];
  logic [DW-1:0]  ctrl_next [NCH];
  logic [NCH-1:0] upd;
  logic [NCH-1:0] en_clr;
  logic [NCH-1:0] end_ev;
  logic [NCH-1:0] bact_clr;
  logic [DW-1:0]  rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Address arithmetic
  function automatic logic [AW-1:0] addr_adv(
    input logic [AW-1:0] a,
    input logic [DW-1:0] ctl,
    input logic          wd
  );
    logic [AW-1:0] inc;
    inc = wd ? 24'h000002 : 24'h000001;
    if (!ctl[B_STEP])
      addr_adv = a;
    else if (ctl[B_DEC])
      addr_adv = a - inc;
    else
      addr_adv = a + inc;
  endfunction

  // Undo n unit steps, taking the address back to its start
  function automatic logic [AW-1:0] addr_back(
    input logic [AW-1:0] a,
    input logic [DW-1:0] ctl,
    input logic          wd,
    input logic [7:0]    n
  );
    logic [AW-1:0] dlt;
    dlt = wd ? {15'h0000, n, 1'b0} : {16'h0000, n};
    if (!ctl[B_STEP])
      addr_back = a;
    else if (ctl[B_DEC])
      addr_back = a + dlt;
    else
      addr_back = a - dlt;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Request pin synchroniser, active low
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ext_meta_reg <= EXT_RST;
      ext_sync_reg <= EXT_RST;
      ext_prev_reg <= EXT_RST;
    end
    else
    begin
      ext_meta_reg <= ext_xfer_req_n_i;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign ext_fall = ext_prev_reg & ~ext_sync_reg;
  assign ext_low  = ~ext_sync_reg;

  ////////////////////////////////////////////////////////////////////
  // Trigger decode and readiness per channel
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      is_full[c]  = (c % 2 == 0) && ctrl_reg[c][B_FULL];
      is_slave[c] = (c % 2 == 1) && ctrl_reg[c & 2][B_FULL];
      is_blk[c]   = is_full[c] && ctrl_reg[c][B_BLOCK];
      // A full pair takes its trigger from the B control word
      sel[c] = is_full[c] ? ctrl_reg[c | 1][B_SEL+:3]
                          : ctrl_reg[c][B_SEL+:3];
      run[c] = ctrl_reg[c][B_EN] && ctrl_reg[c][B_ME];
      auto_rq[c] = is_full[c] && !is_blk[c] && !sel[c][2]
                   && !sel[c][0];
      hit[c] = 1'b0;
      lvl[c] = 1'b0;
      case (sel[c])
        SEL_TMR0, SEL_TMR1, SEL_TMR2, SEL_TMR3:
          hit[c] = (!is_full[c] || is_blk[c])
                   && tmr_cmp_a_i[sel[c][1:0]];
        SEL_SCI_TX:
          hit[c] = !is_full[c] && sci0_tx_empty_i;
        SEL_SCI_RX:
          hit[c] = !is_full[c] && sci0_rx_full_i;
        SEL_EXT_FALL:
          hit[c] = ((c % 2 == 1) || is_full[c])
                   && ext_fall[c / 2];
        SEL_EXT_LOW:
          lvl[c] = ((c % 2 == 1) || (is_full[c] && !is_blk[c]))
                   && ext_low[c / 2];
        default:
          hit[c] = 1'b0;
      endcase
      if (is_slave[c])
        rdy[c] = 1'b0;
      else if (auto_rq[c])
        rdy[c] = run[c];
      else
        rdy[c] = run[c] && (pend_reg[c] || lvl[c] || bact_reg[c]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Fixed priority, channel 0 highest
  always_comb
  begin
    grant = 2'h0;
    any   = 1'b0;
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (rdy[c])
      begin
        grant = 2'(c);
        any   = 1'b1;
      end
    end
  end

  // Bus is kept only through a block or an uninterrupted burst
  assign keep = (state_reg == ST_HOLD) && rdy[cur_reg]
                && (bact_reg[cur_reg]
                    || (auto_rq[cur_reg] && sel[cur_reg] == SEL_BURST
                        && !hp_bus_req_i));
  assign iss    = ((state_reg == ST_IDLE) && any) || keep;
  assign iss_ch = (state_reg == ST_IDLE) ? grant : cur_reg;
  assign iss_b  = {iss_ch[1], 1'b1};
  assign done   = (state_reg == ST_XFER) && xfer_done_i;

  always_comb
  begin
    if (is_full[iss_ch])
    begin
      iss_src = mar_reg[iss_ch];
      iss_dst = mar_reg[iss_b];
    end
    else if (sel[iss_ch] == SEL_SCI_RX)
    begin
      iss_src = {IO_HI, io_side_address_low_reg[iss_ch]};
      iss_dst = mar_reg[iss_ch];
    end
    else
    begin
      iss_src = mar_reg[iss_ch];
      iss_dst = {IO_HI, io_side_address_low_reg[iss_ch]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_reg <= ST_IDLE;
    else
      case (state_reg)
        ST_IDLE:
          if (any)
            state_reg <= ST_XFER;
        ST_XFER:
          if (xfer_done_i)
            state_reg <= ST_HOLD;
        ST_HOLD:
          state_reg <= keep ? ST_XFER : ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cur_reg         <= 2'h0;
      xfer_valid_o    <= 1'b0;
      xfer_src_addr_o <= MAR_RST;
      xfer_dst_addr_o <= MAR_RST;
      xfer_word_o     <= 1'b0;
      bus_own_o       <= 1'b0;
    end
    else if (iss)
    begin
      cur_reg         <= iss_ch;
      xfer_valid_o    <= 1'b1;
      xfer_src_addr_o <= iss_src;
      xfer_dst_addr_o <= iss_dst;
      xfer_word_o     <= ctrl_reg[iss_ch][B_SIZE];
      bus_own_o       <= 1'b1;
    end
    else
    begin
      if (done)
        xfer_valid_o <= 1'b0;
      if (state_reg == ST_HOLD)
        bus_own_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Post-transfer register update for the current channel
  always_comb
  begin
    logic [1:0]    u;
    logic [1:0]    b;
    logic          wd;
    logic          fin;
    logic [DW-1:0] cu;
    u   = cur_reg;
    b   = {cur_reg[1], 1'b1};
    wd  = ctrl_reg[cur_reg][B_SIZE];
    cu  = ctrl_reg[cur_reg];
    fin = 1'b0;
    upd      = '0;
    en_clr   = '0;
    end_ev   = '0;
    bact_clr = '0;
    for (int c = 0; c < NCH; c++)
    begin
      n_mar[c] = mar_reg[c];
      n_cnt[c] = cnt_reg[c];
    end
    if (done)
    begin
      upd[u] = 1'b1;
      if (is_full[u])
      begin
        upd[b]   = 1'b1;
        n_mar[u] = addr_adv(mar_reg[u], cu, wd);
        n_mar[b] = addr_adv(mar_reg[b], ctrl_reg[b], wd);
        if (!is_blk[u])
        begin
          n_cnt[u] = cnt_reg[u] - 16'h0001;
          fin      = (n_cnt[u] == 16'h0000);
        end
        else
        begin
          n_cnt[u][7:0] = cnt_reg[u][7:0] - 8'h01;
          if (n_cnt[u][7:0] == 8'h00)
          begin
            n_cnt[u][7:0] = cnt_reg[u][15:8];
            bact_clr[u]   = 1'b1;
            if (cu[B_TMS])
              n_mar[u] = addr_back(n_mar[u], cu, wd, cnt_reg[u][15:8]);
            else
              n_mar[b] = addr_back(n_mar[b], ctrl_reg[b], wd,
                                   cnt_reg[u][15:8]);
            n_cnt[b] = cnt_reg[b] - 16'h0001;
            fin      = (n_cnt[b] == 16'h0000);
          end
        end
      end
      else
        case (cu[B_SMODE+:2])
          SM_IDLE:
          begin
            n_cnt[u] = cnt_reg[u] - 16'h0001;
            fin      = (n_cnt[u] == 16'h0000);
          end
          SM_RPT:
          begin
            n_mar[u]       = addr_adv(mar_reg[u], cu, wd);
            n_cnt[u][15:8] = cnt_reg[u][15:8] - 8'h01;
            if (n_cnt[u][15:8] == 8'h00)
            begin
              n_cnt[u][15:8] = cnt_reg[u][7:0];
              n_mar[u] = addr_back(n_mar[u], cu, wd, cnt_reg[u][7:0]);
            end
          end
          default:
          begin
            n_mar[u] = addr_adv(mar_reg[u], cu, wd);
            n_cnt[u] = cnt_reg[u] - 16'h0001;
            fin      = (n_cnt[u] == 16'h0000);
          end
        endcase
      en_clr[u] = fin;
      end_ev[u] = fin && cu[B_IRQ];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      ctrl_next[c] = ctrl_reg[c];
      if (reg_wr_i && reg_addr_i == (8'(c * 16) | 8'(OFF_CTRL)))
        ctrl_next[c] = reg_wdata_i & CTRL_WMASK;
      else if (en_clr[c])
        ctrl_next[c][B_EN] = 1'b0;
      // NMI frees the bus; state stays for a later resume
      if (nmi_i)
        ctrl_next[c][B_ME] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        mar_reg[c]  <= MAR_RST;
        io_side_address_low_reg[c] <= IO_SIDE_ADDRESS_LOW_RST;
        cnt_reg[c]  <= CNT_RST;
        ctrl_reg[c] <= CTRL_RST;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        // Software write wins over the hardware update
        if (reg_wr_i && reg_addr_i == (8'(c * 16) | 8'(OFF_MAR)))
          mar_reg[c] <= reg_wdata_i[AW-1:0];
        else if (upd[c])
          mar_reg[c] <= n_mar[c];
        if (reg_wr_i && reg_addr_i == (8'(c * 16) | 8'(OFF_IO_SIDE_ADDRESS_LOW)))
          io_side_address_low_reg[c] <= reg_wdata_i[7:0];
        if (reg_wr_i && reg_addr_i == (8'(c * 16) | 8'(OFF_CNT)))
          cnt_reg[c] <= reg_wdata_i[15:0];
        else if (upd[c])
          cnt_reg[c] <= n_cnt[c];
        ctrl_reg[c] <= ctrl_next[c];
      end
    end
  end

  // Request latches: a new event beats the clear of the same cycle
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pend_reg <= '0;
      bact_reg <= '0;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        pend_reg[c] <= (pend_reg[c] && !(iss && iss_ch == 2'(c)))
                       || (hit[c] && run[c]);
        bact_reg[c] <= (bact_reg[c] && !bact_clr[c])
                       || (iss && iss_ch == 2'(c) && is_blk[c]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      xfer_end_o <= '0;
    else
      xfer_end_o <= end_ev;
  end

  ////////////////////////////////////////////////////////////////////
  // Read port
  always_comb
  begin
    logic [1:0] ch;
    ch     = reg_addr_i[5:4];
    rd_mux = '0;
    if (reg_addr_i < MAP_END)
      case (reg_addr_i[3:0])
        OFF_MAR:  rd_mux = {8'h00, mar_reg[ch]};
        OFF_IO_SIDE_ADDRESS_LOW: rd_mux = {24'h000000, io_side_address_low_reg[ch]};
        OFF_CNT:  rd_mux = {16'h0000, cnt_reg[ch]};
        OFF_CTRL:
        begin
          rd_mux         = ctrl_reg[ch];
          rd_mux[B_PEND] = pend_reg[ch];
          rd_mux[B_BACT] = bact_reg[ch];
        end
        default:  rd_mux = '0;
      endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
  end

endmodule

`default_nettype wire

// *** bench/dmace_engine_asserts.sv ***
// Concurrent checks on the move port and completion outputs.
// Assumes it is bound to the engine and sees only the engine's ports.
`timescale 1ns/1ps
`default_nettype none

module dmace_engine_asserts (
  input  wire logic                      clk_sys_i,
  input  wire logic                      nrst_i,
  input  wire logic                      xfer_done_i,
  input  wire logic                      xfer_valid_o,
  input  wire logic [dmace_pkg::AW-1:0]  xfer_src_addr_o,
  input  wire logic [dmace_pkg::AW-1:0]  xfer_dst_addr_o,
  input  wire logic                      xfer_word_o,
  input  wire logic                      bus_own_o,
  input  wire logic [dmace_pkg::NCH-1:0] xfer_end_o
);
  import dmace_pkg::*;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////
  valid_hold_a: assert property (
    xfer_valid_o && !xfer_done_i |=> xfer_valid_o)
    else $error("move request dropped before completion");
  addr_hold_a: assert property (
    xfer_valid_o && !xfer_done_i |=>
      $stable(xfer_src_addr_o) && $stable(xfer_dst_addr_o))
    else $error("move address changed while pending");
  size_hold_a: assert property (
    xfer_valid_o && !xfer_done_i |=> $stable(xfer_word_o))
    else $error("move size changed while pending");
  move_gap_a: assert property (
    xfer_valid_o && xfer_done_i |=> !xfer_valid_o)
    else $error("no idle cycle after a completed move");
  own_move_a: assert property (
    xfer_valid_o |-> bus_own_o)
    else $error("move requested without bus ownership");
  own_release_a: assert property (
    $fell(bus_own_o) |-> !$past(xfer_valid_o))
    else $error("bus released in the middle of a move");
  end_cause_a: assert property (
    xfer_end_o != '0 |-> $past(xfer_valid_o) && $past(xfer_done_i))
    else $error("completion pulse without a finished move");
  end_pulse_a: assert property (
    xfer_end_o != '0 |=> xfer_end_o == '0)
    else $error("completion pulse longer than one cycle");

endmodule

bind dmace_engine dmace_engine_asserts i_dmace_engine_asserts (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .xfer_done_i(xfer_done_i),
  .xfer_valid_o(xfer_valid_o), .xfer_src_addr_o(xfer_src_addr_o),
  .xfer_dst_addr_o(xfer_dst_addr_o), .xfer_word_o(xfer_word_o),
  .bus_own_o(bus_own_o), .xfer_end_o(xfer_end_o)
);

`default_nettype wire

// *** bench/dmace_bus_agent.sv ***
// Bus agent model that carries out one unit move per request.
// Assumes the engine holds its request until it sees the done pulse.
`timescale 1ns/1ps
`default_nettype none

module dmace_bus_agent (
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       xfer_valid_i,
  input  wire logic [3:0] wait_i,
  output logic            xfer_done_o
);
  logic [3:0] cnt_reg;

  // Answers wait_i+1 cycles after the request, once per unit; never early
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg     <= 4'h0;
      xfer_done_o <= 1'b0;
    end
    else if (xfer_done_o || !xfer_valid_i)
    begin
      cnt_reg     <= 4'h0;
      xfer_done_o <= 1'b0;
    end
    else if (cnt_reg == wait_i)
      xfer_done_o <= 1'b1;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

endmodule

`default_nettype wire

// *** bench/dmace_engine_tb_top.sv ***
// Self-checking bench of the DMA channel mode engine.
// Assumes the engine, its checker and the bus agent model are compiled.
`timescale 1ns/1ps
`default_nettype none

module dmace_engine_tb_top;
  import dmace_pkg::*;

  localparam logic [23:0] IOA = 24'hffff44;

  logic           clk_sys_i, nrst_i, reg_wr_i, reg_rd_i, sci0_tx_empty_i;
  logic           sci0_rx_full_i, nmi_i, hp_bus_req_i, xfer_done_i;
  logic           xfer_valid_o, xfer_word_o, bus_own_o, own_q, wsz;
  logic [RAW-1:0] reg_addr_i;
  logic [DW-1:0]  reg_wdata_i, reg_rdata_o;
  logic [3:0]     tmr_cmp_a_i, xfer_end_o, ends, wait_cyc;
  logic [1:0]     ext_xfer_req_n_i;
  logic [AW-1:0]  xfer_src_addr_o, xfer_dst_addr_o;
  logic [AW-1:0]  ms[$], md[$];
  logic [31:0]    wmax[3] = '{32'h00ff_ffff, 32'h0000_00ff, 32'h0000_ffff};
  int             bad_count, num_checks, cyc, falls;

  dmace_engine i_dmace_engine (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .tmr_cmp_a_i(tmr_cmp_a_i),
    .sci0_tx_empty_i(sci0_tx_empty_i), .sci0_rx_full_i(sci0_rx_full_i),
    .ext_xfer_req_n_i(ext_xfer_req_n_i), .nmi_i(nmi_i),
    .hp_bus_req_i(hp_bus_req_i), .xfer_done_i(xfer_done_i),
    .xfer_valid_o(xfer_valid_o), .xfer_src_addr_o(xfer_src_addr_o),
    .xfer_dst_addr_o(xfer_dst_addr_o), .xfer_word_o(xfer_word_o),
    .bus_own_o(bus_own_o), .xfer_end_o(xfer_end_o)
  );

  dmace_bus_agent i_dmace_bus_agent (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .xfer_valid_i(xfer_valid_o),
    .wait_i(wait_cyc), .xfer_done_o(xfer_done_i)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Records finished moves, completion pulses and bus releases
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    own_q <= bus_own_o;
    if (own_q === 1'b1 && bus_own_o === 1'b0)
      falls++;
    if (xfer_valid_o === 1'b1 && xfer_done_i === 1'b1)
    begin
      ms.push_back(xfer_src_addr_o);
      md.push_back(xfer_dst_addr_o);
      wsz = xfer_word_o;
    end
    ends = ends | xfer_end_o;
    if (cyc == 30000)
    begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, got);
    num_checks++;
    if (exp !== got)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, e, reg_rdata_o);
  endtask

  task automatic prog(input int ch, input logic [23:0] memory_side_address,
                      input logic [15:0] cnt, input logic [31:0] ctl);
    wr(8'(ch * 16), {8'h00, memory_side_address});
    wr(8'(ch * 16 + 4), 32'h0000_0044);
    wr(8'(ch * 16 + 8), {16'h0000, cnt});
    wr(8'(ch * 16 + 12), ctl);
    ends = 4'h0;
  endtask

  // Pin requests are held low long enough to pass the synchroniser
  task automatic fire(input logic [2:0] sel);
    @(posedge clk_sys_i);
    if (sel < 3'h4)
      tmr_cmp_a_i[sel[1:0]] <= 1'b1;
    else if (sel == 3'h4)
      sci0_tx_empty_i <= 1'b1;
    else if (sel == 3'h5)
      sci0_rx_full_i <= 1'b1;
    else
      ext_xfer_req_n_i <= 2'b10;
    @(posedge clk_sys_i);
    tmr_cmp_a_i     <= 4'h0;
    sci0_tx_empty_i <= 1'b0;
    sci0_rx_full_i  <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    ext_xfer_req_n_i <= 2'b11;
  endtask

  task automatic mv(input logic [23:0] s, d);
    int n = 0;
    while (ms.size() == 0 && n < 300)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    if (ms.size() == 0)
      chk("move seen", 32'h1, 32'h0);
    else
    begin
      chk("source", {8'h00, s}, {8'h00, ms.pop_front()});
      chk("destination", {8'h00, d}, {8'h00, md.pop_front()});
    end
  endtask

  task automatic gap();
    repeat (20) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    tmr_cmp_a_i = 4'h0;
    sci0_tx_empty_i = 1'b0;
    sci0_rx_full_i = 1'b0;
    ext_xfer_req_n_i = 2'b11;
    nmi_i = 1'b0;
    hp_bus_req_i = 1'b0;
    wait_cyc = 4'h0;
    ends = 4'h0;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 'h44; a += 4)
      rd(8'(a), 32'h0, "reset value");
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, "unmapped");
    for (int r = 0; r < 3; r++)
    begin
      wr(8'(48 + 4 * r), 32'hffff_ffff);
      rd(8'(48 + 4 * r), wmax[r], "register width");
    end
    // Every trigger code on a B channel, one unit each
    for (int s = 0; s < 8; s++)
    begin
      prog(1, 24'h002000, 16'h0001, 32'h4015 | (s << 8));
      fire(3'(s));
      if (s == 5)
        mv(IOA, 24'h002000);
      else
        mv(24'h002000, IOA);
      gap();
      chk("end flag", 32'h1, {31'h0, ends[1]});
      rd(8'h1c, 32'h4014 | (s << 8), "control");
    end
    prog(0, 24'h002000, 16'h0001, 32'h4615);
    fire(3'h6);
    gap();
    chk("pin on A channel", 32'h0, ms.size());
    wr(8'h0c, 32'h0);
    prog(1, 24'h001000, 16'h0003, 32'h401f);
    for (int i = 0; i < 3; i++)
    begin
      chk("end early", 32'h0, {28'h0, ends});
      fire(3'h0);
      mv(24'h001000 - 2 * i, IOA);
    end
    gap();
    chk("end flag", 32'h2, {28'h0, ends});
    rd(8'h10, 32'h000ffa, "address");
    rd(8'h18, 32'h0, "count");
    chk("word size", 32'h1, {31'h0, wsz});
    // Zero start count runs the full 16-bit range, so no end here
    prog(1, 24'h001000, 16'h0000, 32'h4015);
    fire(3'h0);
    mv(24'h001000, IOA);
    gap();
    chk("byte size", 32'h0, {31'h0, wsz});
    rd(8'h18, 32'h0000ffff, "count");
    rd(8'h1c, 32'h4015, "control");
    wr(8'h1c, 32'h0);
    prog(3, 24'h004000, 16'h0002, 32'h4435);
    repeat (2)
    begin
      fire(3'h4);
      mv(24'h004000, IOA);
    end
    prog(2, 24'h003000, 16'h0202, 32'h4155);
    for (int i = 0; i < 3; i++)
    begin
      fire(3'h1);
      mv(24'h003000 + (i % 2), IOA);
    end
    gap();
    chk("no end", 32'h0, {28'h0, ends});
    rd(8'h2c, 32'h4155, "control");
    wr(8'h2c, 32'h0);
    prog(0, 24'h00a000, 16'h0001, 32'h4215);
    prog(1, 24'h00b000, 16'h0001, 32'h4215);
    fire(3'h2);
    mv(24'h00a000, IOA);
    mv(24'h00b000, IOA);
    // Burst, cycle steal, burst against a higher master; slow agent
    for (int m = 0; m < 3; m++)
    begin
      wait_cyc <= 4'h3;
      hp_bus_req_i <= (m == 2);
      prog(1, 24'h006000, 16'h0000, 32'h4005 | (m == 1 ? 32'h200 : 32'h0));
      falls = 0;
      prog(0, 24'h005000, 16'h0003, 32'h4805);
      for (int i = 0; i < 3; i++)
        mv(24'h005000 + i, 24'h006000 + i);
      gap();
      chk("bus releases", m > 0 ? 3 : 1, falls);
      wr(8'h1c, 32'h0);
    end
    wait_cyc <= 4'h0;
    hp_bus_req_i <= 1'b0;
    prog(3, 24'h008000, 16'h0002, 32'h4305);
    prog(2, 24'h007000, 16'h0202, 32'h5815);
    for (int i = 0; i < 4; i++)
    begin
      if (i % 2 == 0)
        fire(3'h3);
      mv(24'h007000 + i, 24'h008000 + (i % 2));
    end
    gap();
    chk("block end", 32'h1, {31'h0, |ends});
    // Channel 0 still holds full mode and would slave channel 1
    wr(8'h0c, 32'h0);
    prog(1, 24'h00c000, 16'h0002, 32'h4015);
    @(posedge clk_sys_i);
    nmi_i <= 1'b1;
    @(posedge clk_sys_i);
    nmi_i <= 1'b0;
    rd(8'h1c, 32'h0015, "control");
    fire(3'h0);
    gap();
    chk("suspended", 32'h0, ms.size());
    wr(8'h1c, 32'h4015);
    fire(3'h0);
    mv(24'h00c000, IOA);
    test_done();
  end

endmodule

`default_nettype wire
